// file: design/lhp_device.sv
// LCD controller host-port end: parallel and serial capture, bus drive
`timescale 1ns/1ps
module lhp_device #(
	parameter int OSC_DIV = 8
) (
	lhp_if.device port,
	input wire logic clock,
	input wire logic rst,
	output logic [7:0] rxByte,
	output logic rxIsData,
	output logic rxValid,
	input wire logic [7:0] readByte,
	output logic readTaken,
	output logic oscRunning,
	output logic displayClock,
	output logic useInternalRef,
	output logic inInit
);
	initial begin
		if (OSC_DIV < 2) $error("OSC_DIV must be at least 2");
	end
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int NS = 15;
	logic [NS-1:0] rawIn;
	logic [NS-1:0] s1_ff;
	logic [NS-1:0] s2_ff;
	logic [NS-1:0] s3_ff;
	assign rawIn = {port.dBus, port.cmdDataSelect, port.chipSelLow_n, port.chipSelHigh,
		port.rdPin, port.wrPin, port.init_n, port.dotTimingPin};
	// Two-stage sync plus one history stage for edges
	always_ff @(posedge clock) begin
		if (rst) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
		end else begin
			s1_ff <= rawIn;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	logic [7:0] busIn;
	logic kindIn;
	logic selected;
	logic rdNow;
	logic rdOld;
	logic wrNow;
	logic wrOld;
	logic initLow;
	logic dotNow;
	logic dotOld;
	assign busIn = s2_ff[14:7];
	assign kindIn = s2_ff[6];
	assign selected = !s2_ff[5] && s2_ff[4];
	assign rdNow = s2_ff[3];
	assign rdOld = s3_ff[3];
	assign wrNow = s2_ff[2];
	assign wrOld = s3_ff[2];
	assign initLow = !s2_ff[1];
	assign dotNow = s2_ff[0];
	assign dotOld = s3_ff[0];
	// ------------------------------------------------------------
	// Straps caught while in reset
	// ------------------------------------------------------------
	// Bit positions of the strap pins inside the strap synchroniser
	localparam int SP_LINK = 3;
	localparam int SP_STYLE = 2;
	localparam int SP_OSC = 1;
	localparam int SP_REF = 0;
	logic [3:0] strapRaw;
	logic [3:0] strapS1_ff;
	logic [3:0] strapS2_ff;
	logic parMode_ff;
	logic enStyle_ff;
	logic oscSel_ff;
	logic inReset;
	assign strapRaw = {port.linkTypeSelect, port.busStyleSelect, port.oscSourceSelect,
		port.refOriginSelect};
	assign inReset = rst || initLow;
	// Strap pins pass two stages as well; they lag by the same two cycles as
	// the init pin, so a strap moved together with init is still caught in reset
	always_ff @(posedge clock) begin
		strapS1_ff <= strapRaw;
		strapS2_ff <= strapS1_ff;
	end
	// Straps follow synced pins only during reset, then freeze
	always_ff @(posedge clock) begin
		if (inReset) begin
			parMode_ff <= strapS2_ff[SP_LINK] == lhp_pkg::LINK_PARALLEL;
			enStyle_ff <= strapS2_ff[SP_STYLE] == lhp_pkg::STYLE_ENABLE;
			oscSel_ff <= strapS2_ff[SP_OSC];
			useInternalRef <= strapS2_ff[SP_REF];
		end
	end
	// ------------------------------------------------------------
	// Receive: parallel strobes and serial shifter
	// ------------------------------------------------------------
	logic [7:0] shift_ff;
	logic [2:0] bitCnt_ff;
	logic serRise;
	logic wrCapture;
	logic enFall;
	logic isRead;
	assign serRise = !parMode_ff && busIn[lhp_pkg::SER_CLK_BIT] && !s3_ff[14-7+lhp_pkg::SER_CLK_BIT+7-7];
	assign wrCapture = parMode_ff && !enStyle_ff && wrNow && !wrOld;
	assign enFall = parMode_ff && enStyle_ff && !rdNow && rdOld;
	assign isRead = enStyle_ff ? (wrNow == lhp_pkg::DIR_READ) : !rdNow;
	// Byte capture and routing by the command/data line
	always_ff @(posedge clock) begin
		if (inReset) begin
			shift_ff <= '0;
			bitCnt_ff <= '0;
			rxByte <= '0;
			rxIsData <= 1'b0;
			rxValid <= 1'b0;
			readTaken <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			readTaken <= 1'b0;
			if (selected) begin
				if (wrCapture || (enFall && wrOld == lhp_pkg::DIR_WRITE)) begin
					rxByte <= busIn;
					rxIsData <= kindIn == lhp_pkg::KIND_DATA;
					rxValid <= 1'b1;
				end
				if (enFall && wrOld == lhp_pkg::DIR_READ) readTaken <= 1'b1;
				if (!enStyle_ff && parMode_ff && rdNow && !rdOld) readTaken <= 1'b1;
				if (serRise) begin
					shift_ff <= {shift_ff[6:0], busIn[lhp_pkg::SER_DATA_BIT]};
					bitCnt_ff <= bitCnt_ff + 3'h1;
					if (bitCnt_ff == 3'h7) begin
						rxByte <= {shift_ff[6:0], busIn[lhp_pkg::SER_DATA_BIT]};
						rxIsData <= kindIn == lhp_pkg::KIND_DATA;
						rxValid <= 1'b1;
					end
				end
			end else begin
				bitCnt_ff <= '0;
			end
		end
	end
	// ------------------------------------------------------------
	// Data bus drive
	// ------------------------------------------------------------
	logic driveWin;
	// Enable style drives while the enable is high with direction read;
	// strobe style drives while the read strobe is low. Serial never drives.
	assign driveWin = selected && parMode_ff && isRead && (enStyle_ff ? rdNow : 1'b1);
	// Drive the bus only when selected, parallel and reading
	always_ff @(posedge clock) begin
		if (inReset) begin
			port.dDevOe_n <= '1;
			port.dDev <= '0;
		end else begin
			port.dDevOe_n <= driveWin ? 8'h00 : 8'hFF;
			port.dDev <= readByte;
		end
	end
	// ------------------------------------------------------------
	// Display clock source
	// ------------------------------------------------------------
	logic [$clog2(OSC_DIV)-1:0] oscCnt_ff;
	logic oscTick_ff;
	// Internal oscillator runs only when strapped on
	always_ff @(posedge clock) begin
		if (inReset || !oscSel_ff) begin
			oscCnt_ff <= '0;
			oscTick_ff <= 1'b0;
		end else if (oscCnt_ff == $bits(oscCnt_ff)'(OSC_DIV - 1)) begin
			oscCnt_ff <= '0;
			oscTick_ff <= !oscTick_ff;
		end else begin
			oscCnt_ff <= oscCnt_ff + 1'b1;
		end
	end
	// Clock out: own oscillator or synced external pin
	always_ff @(posedge clock) begin
		if (rst) begin
			displayClock <= 1'b0;
			oscRunning <= 1'b0;
			inInit <= 1'b1;
		end else begin
			oscRunning <= oscSel_ff;
			displayClock <= oscSel_ff ? oscTick_ff : (dotNow && dotOld);
			inInit <= initLow;
		end
	end
endmodule : lhp_device

// file: design/lhp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lhp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_ff;
	logic [AW:0] rdPtr_ff;
	logic full;
	logic empty;
	assign full = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
	assign empty = wrPtr_ff == rdPtr_ff;
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_ff[AW-1:0]];
	// Storage write
	always_ff @(posedge clock) begin
		if (inValid && !full) mem[wrPtr_ff[AW-1:0]] <= inData;
	end
	// Pointers
	always_ff @(posedge clock) begin
		if (rst) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
		end else begin
			if (inValid && !full) wrPtr_ff <= wrPtr_ff + 1'b1;
			if (outReady && !empty) rdPtr_ff <= rdPtr_ff + 1'b1;
		end
	end
endmodule : lhp_fifo

// file: design/lhp_host.sv
// Host controller end: register port, FIFO, link pin sequencing
`timescale 1ns/1ps
module lhp_host #(
	parameter int DEPTH = lhp_pkg::FIFO_DEPTH
) (
	lhp_if.host port,
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [15:0] rdData
);
	localparam int HC = lhp_pkg::HALF_CYC;
	// ------------------------------------------------------------
	// Registers and FIFO
	// ------------------------------------------------------------
	logic [5:0] ctrl_ff;
	logic [7:0] rdByte_ff;
	logic fifoInReady;
	logic [8:0] fifoOut;
	logic fifoOutValid;
	logic pop;
	logic busy_ff;
	// Control register; link and style strap levels follow its bits
	always_ff @(posedge clock) begin
		if (rst) ctrl_ff <= 6'(1 << lhp_pkg::CTRL_PAR); // Parallel link out of reset
		else if (wrStb && addr == lhp_pkg::REG_CTRL) ctrl_ff <= wrData[5:0];
	end
	lhp_fifo #(.WIDTH(9), .DEPTH(DEPTH)) uFifo (
		.clock(clock),
		.rst(rst),
		.inData({wrData[8], wrData[7:0]}),
		.inValid(wrStb && addr == lhp_pkg::REG_WDATA),
		.inReady(fifoInReady),
		.outData(fifoOut),
		.outValid(fifoOutValid),
		.outReady(pop)
	);
	// Read port, data the cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst) rdData <= '0;
		else if (rdStb) begin
			case (addr)
				lhp_pkg::REG_CTRL: rdData <= {10'h000, ctrl_ff};
				lhp_pkg::REG_STAT: rdData <= {13'h0, fifoOutValid, !fifoInReady, busy_ff};
				lhp_pkg::REG_RDATA: rdData <= {8'h00, rdByte_ff};
				default: rdData <= '0;
			endcase
		end else rdData <= '0;
	end
	// ------------------------------------------------------------
	// Link sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_SETUP = 3'h1, ST_ACT = 3'h2, ST_HOLD = 3'h3, ST_SER = 3'h4
	} lhp_st_t;
	lhp_st_t st_ff;
	logic [7:0] cnt_ff;
	logic [3:0] bit_ff;
	logic [8:0] cur_ff;
	logic rdOp;
	logic opRd_ff;
	assign rdOp = ctrl_ff[lhp_pkg::CTRL_READ] && ctrl_ff[lhp_pkg::CTRL_PAR];
	// Queued bytes leave only while go is set
	assign pop = st_ff == ST_IDLE && fifoOutValid && !rdOp && ctrl_ff[lhp_pkg::CTRL_GO];
	// Pin sequencing per mode
	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff <= ST_IDLE;
			cnt_ff <= '0;
			bit_ff <= '0;
			cur_ff <= '0;
			busy_ff <= 1'b0;
			opRd_ff <= 1'b0;
			rdByte_ff <= '0;
			port.chipSelLow_n <= 1'b1;
			port.chipSelHigh <= 1'b0;
			port.rdPin <= 1'b1;
			port.wrPin <= 1'b1;
			port.dHost <= '0;
			port.dHostOe_n <= '1;
			port.cmdDataSelect <= 1'b0;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
			unique case (st_ff)
				ST_IDLE: begin
					busy_ff <= 1'b0;
					port.rdPin <= ctrl_ff[lhp_pkg::CTRL_STYLE] ? 1'b0 : 1'b1;
					if (pop || (rdOp && ctrl_ff[lhp_pkg::CTRL_GO])) begin
						busy_ff <= 1'b1;
						opRd_ff <= rdOp; // Direction fixed for the whole transfer
						cur_ff <= fifoOut;
						cnt_ff <= '0;
						bit_ff <= '0;
						port.chipSelLow_n <= 1'b0;
						port.chipSelHigh <= 1'b1;
						port.cmdDataSelect <= rdOp ? ctrl_ff[lhp_pkg::CTRL_KIND] : fifoOut[8];
						port.wrPin <= ctrl_ff[lhp_pkg::CTRL_STYLE] ? rdOp : 1'b1;
						// Serial link starts with its clock low so the first bit rises
						port.dHost <= ctrl_ff[lhp_pkg::CTRL_PAR] ? fifoOut[7:0] : 8'h00;
						port.dHostOe_n <= rdOp ? 8'hFF : (ctrl_ff[lhp_pkg::CTRL_PAR] ? 8'h00 : 8'h3F);
						st_ff <= ctrl_ff[lhp_pkg::CTRL_PAR] ? ST_SETUP : ST_SER;
					end
				end
				ST_SETUP: if (cnt_ff == 8'(HC)) begin
					cnt_ff <= '0;
					st_ff <= ST_ACT;
					if (ctrl_ff[lhp_pkg::CTRL_STYLE]) port.rdPin <= 1'b1;
					else if (opRd_ff) port.rdPin <= 1'b0;
					else port.wrPin <= 1'b0;
				end
				ST_ACT: if (cnt_ff == 8'(HC)) begin
					cnt_ff <= '0;
					st_ff <= ST_HOLD;
					if (opRd_ff) rdByte_ff <= port.dBus;
					port.rdPin <= ctrl_ff[lhp_pkg::CTRL_STYLE] ? 1'b0 : 1'b1;
					port.wrPin <= ctrl_ff[lhp_pkg::CTRL_STYLE] ? port.wrPin : 1'b1;
				end
				ST_SER: if (cnt_ff == 8'(HC)) begin
					cnt_ff <= '0;
					if (bit_ff[0]) begin
						port.dHost[6] <= 1'b0; // Clock low, same data bit held
						port.dHost[7] <= cur_ff[7 - bit_ff[3:1]];
						if (bit_ff == 4'hF) st_ff <= ST_HOLD;
					end else begin
						port.dHost[7] <= cur_ff[7 - bit_ff[3:1]];
						port.dHost[6] <= 1'b1;
					end
					bit_ff <= bit_ff + 4'h1;
				end
				ST_HOLD: if (cnt_ff == 8'(HC)) begin
					port.chipSelLow_n <= 1'b1;
					port.chipSelHigh <= 1'b0;
					port.dHostOe_n <= '1;
					st_ff <= ST_IDLE;
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end
	// Link and style straps and the init level go straight from control bits; oscillator and reference straps stay high
	always_ff @(posedge clock) begin
		if (rst) begin
			port.linkTypeSelect <= 1'b1;
			port.busStyleSelect <= 1'b0;
			port.oscSourceSelect <= 1'b1;
			port.refOriginSelect <= 1'b1;
			port.init_n <= 1'b0;
			port.dotTimingPin <= 1'b0;
		end else begin
			port.linkTypeSelect <= ctrl_ff[lhp_pkg::CTRL_PAR];
			port.busStyleSelect <= ctrl_ff[lhp_pkg::CTRL_STYLE];
			port.init_n <= !ctrl_ff[lhp_pkg::CTRL_INIT];
			port.dotTimingPin <= cnt_ff[4];
		end
	end
endmodule : lhp_host

// file: design/lhp_if.sv
// Interface joining the host controller and the LCD port
`timescale 1ns/1ps
interface lhp_if;
	logic [7:0] dHost;
	logic [7:0] dHostOe_n;
	logic [7:0] dDev;
	logic [7:0] dDevOe_n;
	logic [7:0] dBus;
	logic cmdDataSelect;
	logic chipSelLow_n;
	logic chipSelHigh;
	logic rdPin;
	logic wrPin;
	logic busStyleSelect;
	logic linkTypeSelect;
	logic oscSourceSelect;
	logic refOriginSelect;
	logic init_n;
	logic dotTimingPin;
	// Wired bus: driver with low enable wins, idle lines pull high
	genvar i;
	for (i = 0; i < 8; i++) begin : gWire
		assign dBus[i] = !dHostOe_n[i] ? dHost[i] : (!dDevOe_n[i] ? dDev[i] : 1'b1);
	end
	modport device (input dBus, cmdDataSelect, chipSelLow_n, chipSelHigh, rdPin, wrPin,
		busStyleSelect, linkTypeSelect, oscSourceSelect, refOriginSelect, init_n,
		dotTimingPin, output dDev, dDevOe_n);
	modport host (input dBus, dDev, dDevOe_n, output dHost, dHostOe_n, cmdDataSelect,
		chipSelLow_n, chipSelHigh, rdPin, wrPin, busStyleSelect, linkTypeSelect,
		oscSourceSelect, refOriginSelect, init_n, dotTimingPin);
endinterface : lhp_if

// file: design/lhp_pkg.sv
// Package with shared constants of the LCD host port
package lhp_pkg;
	// ------------------------------------------------------------
	// Bus and mode encodings
	// ------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int SER_DATA_BIT = 7;
	localparam int SER_CLK_BIT = 6;
	localparam int SER_LOW_BITS = 6;
	localparam logic LINK_PARALLEL = 1'h1;
	localparam logic LINK_SERIAL = 1'h0;
	localparam logic STYLE_ENABLE = 1'h1;
	localparam logic STYLE_STROBES = 1'h0;
	localparam logic DIR_READ = 1'h1;
	localparam logic DIR_WRITE = 1'h0;
	localparam logic KIND_DATA = 1'h1;
	localparam logic KIND_CMD = 1'h0;
	// ------------------------------------------------------------
	// Host side register map and timing
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_WDATA = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam logic [3:0] REG_RDATA = 4'h3;
	localparam int CTRL_GO = 0;
	localparam int CTRL_KIND = 1;
	localparam int CTRL_READ = 2;
	localparam int CTRL_PAR = 3;
	localparam int CTRL_STYLE = 4;
	localparam int CTRL_INIT = 5;
	localparam int CLK_HZ = 50000000;
	localparam int HALF_NS = 80;
	localparam int HALF_CYC = (HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int FIFO_DEPTH = 16;
endpackage : lhp_pkg

// file: verif/lhp_sva.sv
// Checker of the device end's bus drive on the joining interface
`timescale 1ns/1ps
module lhp_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] dDevOe_n,
	input wire logic chipSelLow_n,
	input wire logic chipSelHigh,
	input wire logic rdPin,
	input wire logic wrPin,
	input wire logic busStyleSelect,
	input wire logic linkTypeSelect,
	input wire logic init_n
);
	logic sel;
	logic par;
	logic ena;
	// Decoded select and mode pins
	assign sel = !chipSelLow_n && chipSelHigh;
	assign par = linkTypeSelect == lhp_pkg::LINK_PARALLEL;
	assign ena = busStyleSelect == lhp_pkg::STYLE_ENABLE;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_desel;
		(!sel)[*6] |-> dDevOe_n == 8'hFF;
	endproperty
	a_desel: assert property (p_desel) else $error("bus driven while deselected");
	property p_half;
		(!chipSelLow_n && !chipSelHigh)[*6] |-> dDevOe_n == 8'hFF;
	endproperty
	a_half: assert property (p_half) else $error("bus driven on half select");
	property p_serlow;
		(!par && init_n)[*6] |-> dDevOe_n[5:0] == 6'h3F;
	endproperty
	a_serlow: assert property (p_serlow) else $error("low bits driven in serial");
	property p_serial;
		(!par && init_n)[*6] |-> dDevOe_n == 8'hFF;
	endproperty
	a_serial: assert property (p_serial) else $error("bus driven in serial");
	property p_strobe;
		$fell(rdPin) && sel && par && !ena && init_n |-> ##[1:4] dDevOe_n == 8'h00;
	endproperty
	a_strobe: assert property (p_strobe) else $error("no drive on read strobe");
	property p_enread;
		$rose(rdPin) && wrPin == lhp_pkg::DIR_READ && sel && par && ena && init_n
			|-> ##[1:4] dDevOe_n == 8'h00;
	endproperty
	a_enread: assert property (p_enread) else $error("no drive on enable read");
	property p_enwrite;
		(par && ena && wrPin == lhp_pkg::DIR_WRITE)[*6] |-> dDevOe_n == 8'hFF;
	endproperty
	a_enwrite: assert property (p_enwrite) else $error("bus driven on write");
	property p_style;
		(par && !ena && rdPin && init_n)[*6] |-> dDevOe_n == 8'hFF;
	endproperty
	a_style: assert property (p_style) else $error("strobe style drive with read high");
endmodule : lhp_sva

// file: verif/testbench.sv
// Self-checking bench for the host controller and the LCD port ends
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] GO = 16'h0001 << lhp_pkg::CTRL_GO;
	localparam logic [15:0] RD = 16'h0001 << lhp_pkg::CTRL_READ;
	localparam logic [15:0] PAR = 16'h0001 << lhp_pkg::CTRL_PAR;
	localparam logic [15:0] STY = 16'h0001 << lhp_pkg::CTRL_STYLE;
	localparam logic [15:0] INI = 16'h0001 << lhp_pkg::CTRL_INIT;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wrData = 16'h0000;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic [15:0] rdData;
	logic [7:0] readByte = 8'h00;
	logic [7:0] rxByte;
	logic rxIsData;
	logic rxValid;
	logic readTaken;
	logic inInit;
	logic [7:0] rxByte2;
	logic rxValid2;
	logic oscRunning;
	logic displayClock;
	logic useInternalRef;
	logic oscRunning2;
	logic displayClock2;
	logic useInternalRef2;
	logic [8:0] rxQ[$];
	int rx2 = 0;
	int reads = 0;
	int failCount = 0;
	int compares = 0;
	lhp_if lnk();
	lhp_if lnk2();
	lhp_host lhp_host_i (.port(lnk), .clock(clock), .rst(rst), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
	lhp_device lhp_device_i (.port(lnk), .clock(clock), .rst(rst), .rxByte(rxByte),
		.rxIsData(rxIsData), .rxValid(rxValid), .readByte(readByte), .readTaken(readTaken),
		.oscRunning(oscRunning), .displayClock(displayClock), .useInternalRef(useInternalRef),
		.inInit(inInit));
	lhp_device lhp_device_b_i (.port(lnk2), .clock(clock), .rst(rst), .rxByte(rxByte2),
		.rxIsData(), .rxValid(rxValid2), .readByte(8'h00), .readTaken(),
		.oscRunning(oscRunning2), .displayClock(displayClock2),
		.useInternalRef(useInternalRef2), .inInit());
	lhp_sva lhp_sva_i (.clock(clock), .rst(rst), .dDevOe_n(lnk.dDevOe_n),
		.chipSelLow_n(lnk.chipSelLow_n), .chipSelHigh(lnk.chipSelHigh), .rdPin(lnk.rdPin),
		.wrPin(lnk.wrPin), .busStyleSelect(lnk.busStyleSelect),
		.linkTypeSelect(lnk.linkTypeSelect), .init_n(lnk.init_n));
	// Clock toggles every half period
	always #10 clock = ~clock;
	// Second port's pins start idle, half selected, strobe style
	initial begin
		lnk2.chipSelLow_n = 1'b0;
		lnk2.chipSelHigh = 1'b0;
		lnk2.rdPin = 1'b1;
		lnk2.wrPin = 1'b1;
		lnk2.cmdDataSelect = lhp_pkg::KIND_DATA;
		lnk2.busStyleSelect = lhp_pkg::STYLE_STROBES;
		lnk2.linkTypeSelect = lhp_pkg::LINK_PARALLEL;
		lnk2.oscSourceSelect = 1'b1;
		lnk2.refOriginSelect = 1'b1;
		lnk2.init_n = 1'b1;
		lnk2.dotTimingPin = 1'b0;
		lnk2.dHost = 8'h00;
		lnk2.dHostOe_n = 8'hFF;
	end
	// Collect bytes and read completions at the device ends
	always @(posedge clock) begin
		if (rxValid === 1'b1) rxQ.push_back({rxIsData, rxByte});
		if (readTaken === 1'b1) reads++;
		if (rxValid2 === 1'b1) rx2++;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clock);
		wrStb <= 1'b0;
		@(posedge clock);
	endtask : regWrite
	task automatic regRead(input logic [3:0] a, output logic [15:0] d);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clock);
		rdStb <= 1'b0;
		#1 d = rdData;
		@(posedge clock);
	endtask : regRead
	function automatic logic [8:0] pat(input int i);
		return {i[0] ? lhp_pkg::KIND_CMD : lhp_pkg::KIND_DATA, 8'hA5 ^ 8'(i * 27)};
	endfunction : pat
	// Straps change only inside an init period
	task automatic setMode(input logic [15:0] mode);
		int n;
		regWrite(lhp_pkg::REG_CTRL, mode | INI);
		for (n = 0; n < 20 && inInit !== 1'b1; n++) @(posedge clock);
		check(16'(inInit), 16'h0001, "init entry");
		regWrite(lhp_pkg::REG_CTRL, mode);
		for (n = 0; n < 20 && inInit !== 1'b0; n++) @(posedge clock);
		check(16'(inInit), 16'h0000, "init exit");
	endtask : setMode
	// Queue up to FIFO_DEPTH bytes, then let the link carry every queued byte across
	task automatic sc_send(input logic [15:0] mode, input int nw);
		int i;
		int m;
		logic [15:0] st;
		m = nw > lhp_pkg::FIFO_DEPTH ? lhp_pkg::FIFO_DEPTH : nw;
		setMode(mode);
		rxQ.delete();
		for (i = 0; i < nw; i++) regWrite(lhp_pkg::REG_WDATA, 16'(pat(i)));
		regRead(lhp_pkg::REG_STAT, st);
		check(16'(st[1]), 16'(nw >= lhp_pkg::FIFO_DEPTH), "full flag");
		regWrite(lhp_pkg::REG_CTRL, mode | GO);
		for (i = 0; i < 3000 && rxQ.size() < m; i++) @(posedge clock);
		regWrite(lhp_pkg::REG_CTRL, mode);
		check(16'(rxQ.size()), 16'(m), "byte count");
		for (i = 0; i < m && i < rxQ.size(); i++) check({7'h00, rxQ[i]}, 16'(pat(i)), "byte");
		regRead(lhp_pkg::REG_STAT, st);
		check(16'(st[2]), 16'h0000, "drained");
	endtask : sc_send
	// Read back a byte; serial mode must never complete one
	task automatic sc_read(input logic [15:0] mode, input logic [7:0] b);
		int i;
		logic [15:0] d;
		setMode(mode);
		readByte <= b;
		reads = 0;
		regWrite(lhp_pkg::REG_CTRL, mode | GO | RD);
		for (i = 0; i < 400 && reads == 0; i++) @(posedge clock);
		regWrite(lhp_pkg::REG_CTRL, mode);
		// Let a repeat read already under way finish before the mode moves
		repeat (20) @(posedge clock);
		check(16'(reads > 0), 16'((mode & PAR) != 0), "read done");
		regRead(lhp_pkg::REG_RDATA, d);
		if ((mode & PAR) != 0) check(16'(d[7:0]), 16'(b), "read byte");
	endtask : sc_read
	task automatic pulseWr2;
		lnk2.wrPin <= 1'b0;
		repeat (6) @(posedge clock);
		lnk2.wrPin <= 1'b1;
		repeat (8) @(posedge clock);
	endtask : pulseWr2
	// Hand-driven port: half select ignored, full select captures
	task automatic sc_half_select;
		lnk2.dHost <= 8'hC3;
		lnk2.dHostOe_n <= 8'h00;
		pulseWr2;
		lnk2.dHostOe_n <= 8'hFF;
		lnk2.rdPin <= 1'b0;
		repeat (8) @(posedge clock);
		check(16'(lnk2.dDevOe_n), 16'h00FF, "half select drive");
		lnk2.rdPin <= 1'b1;
		check(16'(rx2), 16'h0000, "half select capture");
		lnk2.chipSelHigh <= 1'b1;
		lnk2.dHostOe_n <= 8'h00;
		pulseWr2;
		check(16'(rx2), 16'h0001, "full select capture");
		check(16'(rxByte2), 16'h00C3, "captured byte");
	endtask : sc_half_select
	// Own oscillator and internal reference on one port, pin clock on the other
	task automatic sc_clock_source;
		logic dc0;
		check(16'(oscRunning), 16'h0001, "oscillator on");
		check(16'(useInternalRef), 16'h0001, "internal reference");
		dc0 = displayClock;
		repeat (8) @(posedge clock);
		check(16'(displayClock), 16'(!dc0), "oscillator toggles");
		lnk2.init_n <= 1'b0;
		lnk2.oscSourceSelect <= 1'b0;
		lnk2.refOriginSelect <= 1'b0;
		repeat (6) @(posedge clock);
		lnk2.init_n <= 1'b1;
		repeat (6) @(posedge clock);
		check(16'(oscRunning2), 16'h0000, "oscillator off");
		check(16'(useInternalRef2), 16'h0000, "external reference");
		lnk2.dotTimingPin <= 1'b1;
		repeat (6) @(posedge clock);
		check(16'(displayClock2), 16'h0001, "pin clock high");
		lnk2.dotTimingPin <= 1'b0;
		repeat (6) @(posedge clock);
		check(16'(displayClock2), 16'h0000, "pin clock low");
	endtask : sc_clock_source
	task automatic tally_and_finish;
		if (failCount == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		logic [15:0] d;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		sc_send(PAR, 3);
		sc_send(PAR | STY, 3);
		sc_send(16'h0000, 3);
		sc_send(PAR, 17);
		sc_read(PAR, 8'h5A);
		sc_read(PAR | STY, 8'hC6);
		sc_read(16'h0000, 8'h33);
		regRead(4'hF, d);
		check(d, 16'h0000, "unmapped read");
		sc_half_select;
		sc_clock_source;
		tally_and_finish;
	end
	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge clock);
		failCount++;
		tally_and_finish;
	end
endmodule : testbench
